/* dv/haptic_host_model.sv */
// Host model driving the byte register port
`timescale 1ns/100ps
`default_nettype none
module haptic_host_model (
  // Clock
  input  wire logic       i_core_clk,
  // Register port
  input  wire logic [7:0] i_reg_rdata,
  output logic            o_reg_wr,
  output logic      [7:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata
);
  // ---------------------------------------------------------------
  // Library image as address and data pairs
  // ---------------------------------------------------------------
  // header in page 1, synthesis data in page 2
  // page chosen before each memory block
  // start 0x0100 is page 2 offset 0, stop inclusive
  localparam logic [15:0] LIB [17] = '{
    16'hff01, 16'h0005, 16'h0181, 16'h0200, 16'h0301, 16'h0407, 16'h0501,
    16'hff02, 16'h0000, 16'h01ff, 16'h0201, 16'h0300,
    16'h04ff, 16'h05ff, 16'h0601, 16'h0700, 16'hff00};
  initial begin
    o_reg_wr = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_reg_wr = 1'b1;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(negedge i_core_clk);
    o_reg_wr = 1'b0;
    // Idle data carries no stale value
    o_reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    o_reg_addr = a;
    @(negedge i_core_clk);
    d = i_reg_rdata;
  endtask
  task automatic load_library();
    for (int i = 0; i < 17; i++) begin
      wr(LIB[i][15:8], LIB[i][7:0]);
    end
  endtask
endmodule
`default_nettype wire

/* dv/haptic_seq_props.sv */
// Port checker for the waveform library sequencer
`timescale 1ns/100ps
`default_nettype none
module haptic_seq_props
  import haptic_seq_pkg::*;
(
  // Clock and reset
  input wire logic       i_core_clk,
  input wire logic       i_nrst,
  // Register port
  input wire logic       i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // Amplifier side
  input wire logic [1:0] o_gain,
  input wire logic       o_standby,
  input wire logic       o_busy,
  input wire logic [8:0] o_drive
);
  // ---------------------------------------------------------------
  // Shadow of the page, gain and standby registers
  // ---------------------------------------------------------------
  logic [7:0] page_reg;
  logic [7:0] gain_reg;
  logic       stb_reg;
  logic       wr_d_reg;
  wire  logic ctl     = (page_reg == PAGE_CONTROL);
  wire  logic gain_wr = i_reg_wr && ctl && (i_reg_addr == ADDR_GAIN);
  wire  logic ctrl_wr = i_reg_wr && ctl && (i_reg_addr == ADDR_CTRL);
  wire  logic go_wr   = ctrl_wr && i_reg_wdata[0] && !i_reg_wdata[6];
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      page_reg <= PAGE_RESET;
      gain_reg <= GAIN_RESET;
      stb_reg  <= 1'b1;
      wr_d_reg <= 1'b0;
    end else begin
      wr_d_reg <= gain_wr || ctrl_wr;
      if (i_reg_wr && i_reg_addr == ADDR_PAGE) page_reg <= i_reg_wdata;
      if (gain_wr) gain_reg <= i_reg_wdata;
      if (ctrl_wr) stb_reg <= i_reg_wdata[CTRL_STANDBY_BIT];
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  chk_gain_follow: assert property (!wr_d_reg |-> o_gain == gain_reg[1:0])
    else $error("gain output differs from written gain");
  chk_standby_follow: assert property (!wr_d_reg |-> o_standby == stb_reg)
    else $error("standby output differs from written control");
  chk_busy_start: assert property (go_wr && !o_busy |-> ##3 o_busy)
    else $error("launch did not raise busy three edges later");
  chk_busy_cause: assert property ($rose(o_busy) |-> $past(go_wr, 3))
    else $error("busy rose without a launch write");
  chk_drive_quiet: assert property (!o_busy && !$past(o_busy) |-> o_drive == 9'h000)
    else $error("drive nonzero while idle");
  chk_page_read: assert property (i_reg_addr == ADDR_PAGE && !i_reg_wr |=> o_reg_rdata == page_reg)
    else $error("page select readback wrong");
  chk_unmapped_zero: assert property (ctl && (i_reg_addr == 8'h00 ||
      (i_reg_addr > ADDR_SLOT_LAST && i_reg_addr != ADDR_PAGE)) |=> o_reg_rdata == 8'h00)
    else $error("unmapped control address read nonzero");
  chk_gain_read: assert property (ctl && i_reg_addr == ADDR_GAIN && !i_reg_wr
      |=> o_reg_rdata == gain_reg)
    else $error("gain readback wrong");
  chk_ctrl_bits: assert property (ctl && i_reg_addr == ADDR_CTRL |=> (o_reg_rdata & 8'hbe) == 8'h00)
    else $error("unused control bits read nonzero");
  chk_standby_abort: assert property (ctrl_wr && i_reg_wdata[6] |-> ##[1:3] !o_busy)
    else $error("standby did not stop the engine");
  cover property ($rose(o_busy));
  cover property (o_busy && o_drive != 9'h000);
  cover property (ctrl_wr && i_reg_wdata[6] && i_reg_wdata[0]);
endmodule
bind haptic_seq_top haptic_seq_props u_props (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_gain(o_gain), .o_standby(o_standby), .o_busy(o_busy), .o_drive(o_drive));
`default_nettype wire

/* dv/haptic_waveform_library_sequencer_tb_top.sv */
// Self-checking bench of the waveform library sequencer
`timescale 1ns/100ps
`default_nettype none
module haptic_waveform_library_sequencer_tb_top;
  import haptic_seq_pkg::*;
  logic            clk;
  logic            nrst;
  wire  logic      reg_wr;
  wire  logic [7:0] reg_addr;
  wire  logic [7:0] reg_wdata;
  wire  logic [7:0] reg_rdata;
  wire  logic [1:0] gain;
  wire  logic      standby;
  wire  logic      busy;
  wire  logic [8:0] drive;
  int              failures;
  int              comparisons;
  haptic_seq_top u_dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_reg_wr(reg_wr), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .o_gain(gain),
    .o_standby(standby), .o_busy(busy), .o_drive(drive));
  haptic_host_model u_host (
    .i_core_clk(clk), .i_reg_rdata(reg_rdata), .o_reg_wr(reg_wr),
    .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // Shared checks and verdict
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    logic [7:0] d;
    repeat (3) @(negedge clk);
    chk("standby in reset", 9'h001, standby);
    chk("busy in reset", 9'h000, busy);
    chk("drive in reset", 9'h000, drive);
    nrst = 1'b1;
    u_host.rd(ADDR_PAGE, d);
    chk("page after reset", 9'h000, d);
  endtask
  task automatic t_regs();
    logic [7:0] d;
    u_host.wr(ADDR_CTRL, 8'h00);
    u_host.wr(ADDR_GAIN, 8'h03);
    u_host.rd(ADDR_GAIN, d);
    chk("gain readback", 9'h003, d);
    chk("gain output", 9'h003, gain);
    chk("standby left", 9'h000, standby);
    u_host.wr(ADDR_SLOT_LAST, 8'ha5);
    u_host.rd(ADDR_SLOT_LAST, d);
    chk("last slot", 9'h0a5, d);
    u_host.rd(8'h0b, d);
    chk("unmapped read", 9'h000, d);
    u_host.wr(ADDR_PAGE, 8'h01);
    u_host.wr(8'h00, 8'h1e);
    u_host.rd(8'h00, d);
    chk("header length byte", 9'h01e, d);
    u_host.wr(ADDR_PAGE, 8'h09);
    u_host.rd(8'h00, d);
    chk("page beyond memory", 9'h000, d);
    u_host.wr(ADDR_PAGE, PAGE_CONTROL);
    u_host.rd(ADDR_GAIN, d);
    chk("control space back", 9'h003, d);
    u_host.wr(ADDR_SLOT_LAST, SLOT_END_ID);
  endtask
  task automatic t_play();
    logic [7:0] d;
    logic       neg;
    logic [8:0] peak;
    u_host.load_library();
    u_host.wr(ADDR_SLOT_FIRST, 8'h02);
    u_host.wr(8'h04, 8'h01);
    u_host.wr(8'h05, SLOT_END_ID);
    u_host.wr(ADDR_CTRL, 8'h41);
    repeat (4) @(negedge clk);
    chk("launch in standby", 9'h000, busy);
    u_host.wr(ADDR_CTRL, 8'h01);
    repeat (3) @(negedge clk);
    chk("busy after launch", 9'h001, busy);
    u_host.rd(ADDR_CTRL, d);
    chk("launch bit held", 9'h001, d);
    for (int n = 0; n < 9000 && drive === 9'h000; n++) begin
      @(negedge clk);
    end
    chk("silent entry", 9'h000, drive);
    peak = 9'h000;
    neg = 1'b0;
    for (int n = 0; n < 30000 && busy === 1'b1; n++) begin
      @(negedge clk);
      if (drive[8] === 1'b1) neg = 1'b1;
      else if (drive > peak) peak = drive;
    end
    chk("sequence ended", 9'h000, busy);
    chk("negative half", 9'h001, neg);
    chk("second entry peak", 9'h001, peak > 9'h07f);
    u_host.rd(ADDR_CTRL, d);
    chk("launch bit cleared", 9'h000, d);
    chk("drive after end", 9'h000, drive);
  endtask
  task automatic t_abort();
    logic [7:0] d;
    u_host.wr(ADDR_CTRL, 8'h01);
    repeat (3) @(negedge clk);
    chk("busy on relaunch", 9'h001, busy);
    u_host.wr(ADDR_CTRL, 8'h41);
    repeat (3) @(negedge clk);
    chk("busy after standby", 9'h000, busy);
    chk("standby entered", 9'h001, standby);
    chk("drive in standby", 9'h000, drive);
    u_host.rd(ADDR_CTRL, d);
    chk("launch bit aborted", 9'h040, d);
  endtask
  initial begin
    nrst = 1'b0;
    failures = 0;
    comparisons = 0;
    t_reset();
    t_regs();
    t_play();
    t_abort();
    conclude();
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("[FAIL] watchdog expected end seen timeout");
    conclude();
  end
endmodule
`default_nettype wire

/* logic/haptic_seq_pkg.sv */
// Constants, register map and types for the haptic waveform sequencer
package haptic_seq_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned SAMPLE_RATE_HZ  = 8000;
  localparam int unsigned SAMPLE_TICKS    = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int unsigned RAMP_UNIT_MS    = 32;
  localparam int unsigned ENV_STEPS       = 256;
  localparam int unsigned RAMP_STEP_TICKS =
    (RAMP_UNIT_MS * SAMPLE_RATE_HZ) / (1000 * ENV_STEPS);
  localparam int unsigned PHASE_W         = 10;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_GAIN       = 8'h01;
  localparam logic [7:0] ADDR_CTRL       = 8'h02;
  localparam logic [7:0] ADDR_SLOT_FIRST = 8'h03;
  localparam logic [7:0] ADDR_SLOT_LAST  = 8'h0a;
  localparam logic [7:0] ADDR_PAGE       = 8'hff;
  localparam logic [7:0] PAGE_CONTROL    = 8'h00;
  localparam int unsigned CTRL_GO_BIT      = 0;
  localparam int unsigned CTRL_STANDBY_BIT = 6;
  localparam logic [7:0] GAIN_RESET      = 8'h00;
  localparam logic [7:0] PAGE_RESET      = 8'h00;
  localparam logic [7:0] SLOT_RESET      = 8'h00;
  // ---------------------------------------------------------------
  // Waveform memory layout
  // ---------------------------------------------------------------
  localparam int unsigned RAM_PAGES      = 8;
  localparam int unsigned RAM_AW         = 11;
  localparam int unsigned RAM_BYTES      = 2048;
  localparam int unsigned NUM_SLOTS      = 8;
  localparam int unsigned HDR_LEN_ADDR   = 0;
  localparam int unsigned HDR_FIRST      = 1;
  localparam int unsigned HDR_BYTES      = 5;
  localparam int unsigned SYN_BYTES      = 4;
  localparam int unsigned MODE_FLAG_BIT  = 7;
  localparam logic [7:0] SLOT_END_ID     = 8'h00;
  localparam logic [7:0] ENV_FULL        = 8'hff;
  // Quarter-wave sine, 16 points, full scale 255
  localparam logic [7:0] SINE_Q [16] = '{
    8'h0d, 8'h25, 8'h3e, 8'h56, 8'h6d, 8'h83, 8'h98, 8'hab,
    8'hbd, 8'hcd, 8'hdb, 8'he7, 8'hf0, 8'hf7, 8'hfc, 8'hff};
  // ---------------------------------------------------------------
  // Engine states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SLOT = 3'b001,
    ST_HDR  = 3'b010,
    ST_ENT  = 3'b011,
    ST_PLAY = 3'b100,
    ST_FALL = 3'b101,
    ST_NEXT = 3'b110
  } eng_state_e;
endpackage

/* logic/haptic_seq_top.sv */
// Waveform library sequencer: register file, waveform RAM and playback engine
`timescale 1ns/100ps
`default_nettype none
module haptic_seq_top (
  // Clock and reset
  input  wire logic                   i_core_clk,
  input  wire logic                   i_nrst,
  // Byte register port
  input  wire logic                   i_reg_wr,
  input  wire logic [7:0]             i_reg_addr,
  input  wire logic [7:0]             i_reg_wdata,
  output logic      [7:0]             o_reg_rdata,
  // Amplifier side
  output logic      [1:0]             o_gain,
  output logic                        o_standby,
  output logic                        o_busy,
  output logic      [8:0]             o_drive
);
  import haptic_seq_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]           gain_reg;
  logic                 go_reg;
  logic                 standby_reg;
  logic [7:0]           page_reg;
  logic [7:0]           slot_reg [NUM_SLOTS];
  logic [7:0]           ram_reg [RAM_BYTES];
  eng_state_e           state_reg;
  logic [3:0]           slot_idx_reg;
  logic [RAM_AW-1:0]    start_reg;
  logic [RAM_AW-1:0]    stop_reg;
  logic [RAM_AW-1:0]    cur_reg;
  logic [7:0]           rep_reg;
  logic [7:0]           amp_reg;
  logic [7:0]           freq_reg;
  logic [7:0]           cyc_reg;
  logic [3:0]           rise_reg;
  logic [3:0]           fall_reg;
  logic [7:0]           env_reg;
  logic [7:0]           pre_reg;
  logic [PHASE_W-1:0]   phase_reg;
  logic [11:0]          tick_cnt_reg;
  logic                 tick_reg;

  logic                 ctrl_wr;
  logic                 ctrl_space;
  logic                 ram_hit;
  logic [RAM_AW-1:0]    host_lin;
  logic [7:0]           cur_id;
  logic [RAM_AW-1:0]    hdr_base;
  logic                 hdr_fits;
  logic                 seq_done;
  logic                 playing;
  logic [3:0]           ramp_code;
  logic                 ramp_due;
  logic [PHASE_W:0]     phase_sum;
  logic [3:0]           sine_idx;
  logic [15:0]          mag1;
  logic [15:0]          mag2;

  // ---------------------------------------------------------------
  // Host decode
  // ---------------------------------------------------------------
  assign ctrl_space = (page_reg == PAGE_CONTROL);
  assign ctrl_wr    = i_reg_wr && ctrl_space;
  assign host_lin   = {3'(page_reg - 8'h01), i_reg_addr};
  assign ram_hit    = !ctrl_space && (page_reg <= 8'(RAM_PAGES)) &&
                      (i_reg_addr != ADDR_PAGE);

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      page_reg <= PAGE_RESET;
    end else if (i_reg_wr && i_reg_addr == ADDR_PAGE) begin
      page_reg <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gain_reg <= GAIN_RESET;
    end else if (ctrl_wr && i_reg_addr == ADDR_GAIN) begin
      gain_reg <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      standby_reg <= 1'b1;
    end else if (ctrl_wr && i_reg_addr == ADDR_CTRL) begin
      standby_reg <= i_reg_wdata[CTRL_STANDBY_BIT];
    end
  end

  // launch bit; a host write beats the clear on completion
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      go_reg <= 1'b0;
    end else if (ctrl_wr && i_reg_addr == ADDR_CTRL) begin
      go_reg <= i_reg_wdata[CTRL_GO_BIT];
    end else if (seq_done) begin
      go_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_reg[i] <= SLOT_RESET;
      end
    end else if (ctrl_wr && i_reg_addr >= ADDR_SLOT_FIRST &&
                 i_reg_addr <= ADDR_SLOT_LAST) begin
      slot_reg[3'(i_reg_addr - ADDR_SLOT_FIRST)] <= i_reg_wdata;
    end
  end

  // Waveform RAM, written only through a mapped page
  always_ff @(posedge i_core_clk) begin
    if (i_reg_wr && ram_hit) begin
      ram_reg[host_lin] <= i_reg_wdata;
    end
  end

  // Read data, one cycle after the address
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_addr == ADDR_PAGE) begin
      o_reg_rdata <= page_reg;
    end else if (!ctrl_space) begin
      o_reg_rdata <= ram_hit ? ram_reg[host_lin] : 8'h00;
    end else if (i_reg_addr == ADDR_GAIN) begin
      o_reg_rdata <= gain_reg;
    end else if (i_reg_addr == ADDR_CTRL) begin
      o_reg_rdata <= (8'(standby_reg) << CTRL_STANDBY_BIT) |
                     (8'(go_reg) << CTRL_GO_BIT);
    end else if (i_reg_addr >= ADDR_SLOT_FIRST && i_reg_addr <= ADDR_SLOT_LAST) begin
      o_reg_rdata <= slot_reg[3'(i_reg_addr - ADDR_SLOT_FIRST)];
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Sample tick divider
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_cnt_reg <= 12'h000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 12'(SAMPLE_TICKS - 1)) begin
      tick_cnt_reg <= 12'h000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 12'h001;
      tick_reg     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Engine helpers
  // ---------------------------------------------------------------
  assign cur_id   = slot_reg[slot_idx_reg[2:0]];
  assign hdr_base = RAM_AW'(int'(cur_id) * HDR_BYTES - HDR_BYTES + HDR_FIRST);
  assign hdr_fits = (int'(cur_id) * HDR_BYTES) <= (int'(ram_reg[HDR_LEN_ADDR]) + 1);
  // end at zero ID, after eight slots, or on standby while not idle
  assign seq_done = (state_reg == ST_SLOT &&
                     (slot_idx_reg == 4'(NUM_SLOTS) || cur_id == SLOT_END_ID)) ||
                    (state_reg != ST_IDLE && standby_reg);
  assign playing   = (state_reg == ST_PLAY) || (state_reg == ST_FALL);
  // phase advances by the frequency code each sample
  assign phase_sum = {1'b0, phase_reg} + (PHASE_W + 1)'(freq_reg);
  assign ramp_code = (state_reg == ST_FALL) ? fall_reg : rise_reg;
  // one envelope step per code unit of samples
  assign ramp_due  = tick_reg &&
                     (pre_reg == 8'(int'(ramp_code) * RAMP_STEP_TICKS - 1));

  // ---------------------------------------------------------------
  // Playback engine
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg    <= ST_IDLE;
      slot_idx_reg <= 4'h0;
      start_reg    <= '0;
      stop_reg     <= '0;
      cur_reg      <= '0;
      rep_reg      <= 8'h00;
      amp_reg      <= 8'h00;
      freq_reg     <= 8'h00;
      cyc_reg      <= 8'h00;
      rise_reg     <= 4'h0;
      fall_reg     <= 4'h0;
      env_reg      <= 8'h00;
      pre_reg      <= 8'h00;
      phase_reg    <= '0;
    end else if (seq_done) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (go_reg && !standby_reg) begin
            slot_idx_reg <= 4'h0;
            state_reg    <= ST_SLOT;
          end
        end
        ST_SLOT: begin
          if (hdr_fits) begin
            state_reg <= ST_HDR;
          end else begin
            slot_idx_reg <= slot_idx_reg + 4'h1;
          end
        end
        ST_HDR: begin
          if (!ram_reg[hdr_base][MODE_FLAG_BIT] || ram_reg[hdr_base + 11'd4] == 8'h00) begin
            slot_idx_reg <= slot_idx_reg + 4'h1;
            state_reg    <= ST_SLOT;
          end else begin
            start_reg <= {ram_reg[hdr_base][2:0], ram_reg[hdr_base + 11'd1]};
            cur_reg   <= {ram_reg[hdr_base][2:0], ram_reg[hdr_base + 11'd1]};
            stop_reg  <= {ram_reg[hdr_base + 11'd2][2:0], ram_reg[hdr_base + 11'd3]};
            rep_reg   <= ram_reg[hdr_base + 11'd4];
            state_reg <= ST_ENT;
          end
        end
        ST_ENT: begin
          amp_reg   <= ram_reg[cur_reg];
          freq_reg  <= ram_reg[cur_reg + 11'd1];
          cyc_reg   <= ram_reg[cur_reg + 11'd2];
          rise_reg  <= ram_reg[cur_reg + 11'd3][7:4];
          fall_reg  <= ram_reg[cur_reg + 11'd3][3:0];
          env_reg   <= (ram_reg[cur_reg + 11'd3][7:4] == 4'h0) ? ENV_FULL : 8'h00;
          pre_reg   <= 8'h00;
          phase_reg <= '0;
          if (ram_reg[cur_reg + 11'd1] == 8'h00 || ram_reg[cur_reg + 11'd2] == 8'h00) begin
            state_reg <= ST_NEXT;
          end else begin
            state_reg <= ST_PLAY;
          end
        end
        ST_PLAY: begin
          if (tick_reg) begin
            phase_reg <= phase_sum[PHASE_W-1:0];
            pre_reg   <= ramp_due ? 8'h00 : pre_reg + 8'h01;
            if (ramp_due && env_reg != ENV_FULL) begin
              env_reg <= env_reg + 8'h01;
            end
            if (phase_sum[PHASE_W]) begin
              cyc_reg <= cyc_reg - 8'h01;
              if (cyc_reg == 8'h01) begin
                pre_reg   <= 8'h00;
                state_reg <= (fall_reg == 4'h0) ? ST_NEXT : ST_FALL;
              end
            end
          end
        end
        ST_FALL: begin
          if (tick_reg) begin
            phase_reg <= phase_sum[PHASE_W-1:0];
            pre_reg   <= ramp_due ? 8'h00 : pre_reg + 8'h01;
            if (ramp_due) begin
              env_reg <= env_reg - 8'h01;
              if (env_reg <= 8'h01) begin
                state_reg <= ST_NEXT;
              end
            end
          end
        end
        // next entry, repeat or next slot
        ST_NEXT: begin
          if (cur_reg + 11'(SYN_BYTES - 1) >= stop_reg) begin
            if (rep_reg == 8'h01) begin
              slot_idx_reg <= slot_idx_reg + 4'h1;
              state_reg    <= ST_SLOT;
            end else begin
              rep_reg   <= rep_reg - 8'h01;
              cur_reg   <= start_reg;
              state_reg <= ST_ENT;
            end
          end else begin
            cur_reg   <= cur_reg + 11'(SYN_BYTES);
            state_reg <= ST_ENT;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Drive synthesis
  // ---------------------------------------------------------------
  assign sine_idx = phase_reg[7:4] ^ {4{phase_reg[8]}};
  // linear in amplitude; amplitude zero gives silence
  assign mag1 = {8'h00, SINE_Q[sine_idx]} * {8'h00, amp_reg};
  assign mag2 = {8'h00, mag1[15:8]} * {8'h00, env_reg};

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_drive <= 9'h000;
    end else if (!playing) begin
      o_drive <= 9'h000;
    end else if (phase_reg[9]) begin
      o_drive <= 9'(-{1'b0, mag2[15:8]});
    end else begin
      o_drive <= {1'b0, mag2[15:8]};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_gain    <= 2'b00;
      o_standby <= 1'b1;
      o_busy    <= 1'b0;
    end else begin
      o_gain    <= gain_reg[1:0];
      o_standby <= standby_reg;
      o_busy    <= (state_reg != ST_IDLE);
    end
  end
endmodule
`default_nettype wire
